// ---- common/fwprc_cfg.svh ----
// Purpose: constants for the flash pin controller (host end)
// Assumes: 20 MHz clock, word mode only, 21-bit word address
// Notes: every timing figure but the synchroniser delay is kept in ns and turned into cycles here
`ifndef FWPRC_CFG_SVH
`define FWPRC_CFG_SVH

// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define FWPRC_AW 21
`define FWPRC_DW 16
`define FWPRC_TW 12

// ------------------------------------------------------------
// Address fields used in protect and verify
// ------------------------------------------------------------
`define FWPRC_GRP_HI 20
`define FWPRC_GRP_LO 12
`define FWPRC_A9 9
`define FWPRC_LOW_PROT 7'h02

// ------------------------------------------------------------
// Timing in ns and derived cycle counts (min rounds up)
// ------------------------------------------------------------
`define FWPRC_CLK_NS 50
`define FWPRC_RP_NS 500
`define FWPRC_RH_NS 200
`define FWPRC_ACC_NS 100
`define FWPRC_SETUP_NS 50
`define FWPRC_WLOW_NS 100
`define FWPRC_HOLD_NS 50
`define FWPRC_PPULSE_NS 100000
`define FWPRC_CYC(ns) ((((ns) + `FWPRC_CLK_NS - 1) / `FWPRC_CLK_NS))
`define FWPRC_SYNC_CYC 2

`endif

// ---- common/fwprc_pkg.sv ----
// Purpose: shared types of the flash pin controller
// Assumes: fwprc_cfg.svh on the include path
// Notes: constants live in the header, types here
`include "fwprc_cfg.svh"

package fwprc_pkg;

  // ------------------------------------------------------------
  // User operations
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_WRITE = 4'h1,
    OP_PROTECT = 4'h2,
    OP_VERIFY = 4'h3,
    OP_RESET = 4'h4,
    OP_UNPROT_ON = 4'h5,
    OP_UNPROT_OFF = 4'h6,
    OP_WP_LOW = 4'h7,
    OP_WP_HIGH = 4'h8,
    OP_ACCEL_ON = 4'h9,
    OP_ACCEL_OFF = 4'hA
  } fwprc_op_t;

  // ------------------------------------------------------------
  // Sequencer states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_RD_WAIT = 4'h1,
    ST_WR_SET = 4'h2,
    ST_WR_LOW = 4'h3,
    ST_WR_HOLD = 4'h4,
    ST_PR_SET = 4'h5,
    ST_PR_PULSE = 4'h6,
    ST_PR_HOLD = 4'h7,
    ST_RST_LOW = 4'h8,
    ST_RST_WAIT = 4'h9
  } fwprc_state_t;

  // ------------------------------------------------------------
  // Request and pin bundles
  // ------------------------------------------------------------
  typedef struct packed {
    fwprc_op_t op;
    logic [`FWPRC_AW-1:0] addr;
    logic [`FWPRC_DW-1:0] data;
  } fwprc_req_t;

  typedef struct packed {
    logic [`FWPRC_AW-1:0] addr;
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic rst_n;
    logic [`FWPRC_DW-1:0] dq_out;
    logic dq_oe;
    logic a9_hv;
    logic rst_hv;
    logic protect_accel_pin;
    logic accel_hv;
  } fwprc_pins_t;

endpackage

// ---- verilog/fwprc_timer.sv ----
// Purpose: loadable down counter for pin timing
// Assumes: load wins over counting
// Notes: zero is high while the count has run out
`timescale 1ns/1ps
`default_nettype none

module fwprc_timer #(
  parameter int W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Load
  input wire logic load,
  input wire logic [W-1:0] load_val,
  // Status
  output logic zero
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  // ------------------------------------------------------------
  // Count
  // ------------------------------------------------------------
  // Load or count down to zero
  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != '0) begin
      next_cnt = cnt - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign zero = (cnt == '0);

endmodule

`default_nettype wire

// ---- verilog/fwprc_ctrl.sv ----
// Purpose: host end that drives a parallel NOR flash through its pins
// Assumes: word mode; ready/busy and data pins are asynchronous to clk
// Notes: one user request at a time; pin-sequenced ops hold busy high until done pulses, single-cycle ops never raise busy
`timescale 1ns/1ps
`default_nettype none
`include "fwprc_cfg.svh"

module fwprc_ctrl #(
  parameter int TW = `FWPRC_TW,
  parameter logic [`FWPRC_TW-1:0] PPULSE_CYC = `FWPRC_TW'(`FWPRC_CYC(`FWPRC_PPULSE_NS))
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User request and answer
  input wire logic req_valid,
  input wire fwprc_pkg::fwprc_req_t req,
  output logic busy,
  output logic done,
  output logic err,
  output logic [`FWPRC_DW-1:0] rdata,
  // Flash pins
  output fwprc_pkg::fwprc_pins_t pins,
  input wire logic [`FWPRC_DW-1:0] dq_in,
  input wire logic ry_by
);

  localparam logic [TW-1:0] RP_CYC = TW'(`FWPRC_CYC(`FWPRC_RP_NS));
  localparam logic [TW-1:0] RH_CYC = TW'(`FWPRC_CYC(`FWPRC_RH_NS));
  localparam logic [TW-1:0] RD_CYC = TW'(`FWPRC_CYC(`FWPRC_ACC_NS) + `FWPRC_SYNC_CYC);
  localparam logic [TW-1:0] SET_CYC = TW'(`FWPRC_CYC(`FWPRC_SETUP_NS));
  localparam logic [TW-1:0] WLOW_CYC = TW'(`FWPRC_CYC(`FWPRC_WLOW_NS));
  localparam logic [TW-1:0] HOLD_CYC = TW'(`FWPRC_CYC(`FWPRC_HOLD_NS));

  fwprc_pkg::fwprc_state_t state, next_state;
  fwprc_pkg::fwprc_pins_t next_pins;
  logic next_busy, next_done, next_err;
  logic [`FWPRC_DW-1:0] next_rdata;
  logic [`FWPRC_DW-1:0] dq_s1, dq_s2;
  logic rb_s1, rb_s2;
  logic t_load, t_zero;
  logic [TW-1:0] t_val;

  // Address with high voltage verify/protect low bits applied
  function automatic logic [`FWPRC_AW-1:0] hv_addr(input logic [`FWPRC_AW-1:0] a);
    logic [`FWPRC_AW-1:0] r;
    r = '0;
    r[`FWPRC_GRP_HI:`FWPRC_GRP_LO] = a[`FWPRC_GRP_HI:`FWPRC_GRP_LO];
    r[6:0] = `FWPRC_LOW_PROT;
    return r;
  endfunction

  // ------------------------------------------------------------
  // Pin input synchronisers
  // ------------------------------------------------------------
  // Data and ready/busy come from the flash, not from clk
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1 <= '0;
      dq_s2 <= '0;
      rb_s1 <= 1'h1;
      rb_s2 <= 1'h1;
    end else begin
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
      rb_s1 <= ry_by;
      rb_s2 <= rb_s1;
    end
  end

  fwprc_timer #(.W(TW)) u_timer (
    .clk(clk),
    .rstn(rstn),
    .load(t_load),
    .load_val(t_val),
    .zero(t_zero)
  );

  // ------------------------------------------------------------
  // Sequencer next state
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_done = 1'h0;
    next_err = err;
    next_rdata = rdata;
    t_load = 1'h0;
    t_val = '0;
    case (state)
      fwprc_pkg::ST_IDLE: begin
        if (req_valid) begin
          next_err = 1'h0;
          case (req.op)
            fwprc_pkg::OP_READ: begin
              // Output gate low only after reset recovery (idle implies it)
              next_pins.addr = req.addr;
              next_pins.ce_n = 1'h0;
              next_pins.oe_n = 1'h0;
              next_pins.dq_oe = 1'h0;
              t_load = 1'h1;
              t_val = RD_CYC;
              next_state = fwprc_pkg::ST_RD_WAIT;
            end
            fwprc_pkg::OP_WRITE: begin
              next_pins.addr = req.addr;
              next_pins.ce_n = 1'h0;
              next_pins.oe_n = 1'h1;
              next_pins.dq_out = req.data;
              next_pins.dq_oe = 1'h1;
              t_load = 1'h1;
              t_val = SET_CYC;
              next_state = fwprc_pkg::ST_WR_SET;
            end
            fwprc_pkg::OP_PROTECT: begin
              next_pins.addr = hv_addr(req.addr);
              next_pins.a9_hv = 1'h1;
              next_pins.ce_n = 1'h0;
              next_pins.oe_n = 1'h0;
              next_pins.dq_oe = 1'h0;
              t_load = 1'h1;
              t_val = SET_CYC;
              next_state = fwprc_pkg::ST_PR_SET;
            end
            fwprc_pkg::OP_VERIFY: begin
              // bit one high keeps off identifiers
              next_pins.addr = hv_addr(req.addr);
              next_pins.a9_hv = 1'h1;
              next_pins.ce_n = 1'h0;
              next_pins.oe_n = 1'h0;
              next_pins.dq_oe = 1'h0;
              t_load = 1'h1;
              t_val = RD_CYC;
              next_state = fwprc_pkg::ST_RD_WAIT;
            end
            fwprc_pkg::OP_RESET: begin
              next_pins.rst_n = 1'h0;
              next_pins.ce_n = 1'h1;
              next_pins.oe_n = 1'h1;
              next_pins.dq_oe = 1'h0;
              t_load = 1'h1;
              t_val = RP_CYC;
              next_state = fwprc_pkg::ST_RST_LOW;
            end
            fwprc_pkg::OP_UNPROT_ON: begin
              next_pins.rst_hv = 1'h1;
              next_done = 1'h1;
            end
            fwprc_pkg::OP_UNPROT_OFF: begin
              next_pins.rst_hv = 1'h0;
              next_done = 1'h1;
            end
            fwprc_pkg::OP_WP_LOW: begin
              next_pins.protect_accel_pin = 1'h0;
              next_done = 1'h1;
            end
            fwprc_pkg::OP_WP_HIGH: begin
              next_pins.protect_accel_pin = 1'h1;
              next_done = 1'h1;
            end
            fwprc_pkg::OP_ACCEL_ON: begin
              next_pins.accel_hv = 1'h1;
              next_done = 1'h1;
            end
            fwprc_pkg::OP_ACCEL_OFF: begin
              // refuse while the flash reports busy
              if (rb_s2) begin
                next_pins.accel_hv = 1'h0;
              end else begin
                next_err = 1'h1;
              end
              next_done = 1'h1;
            end
            default: begin
              next_err = 1'h1;
              next_done = 1'h1;
            end
          endcase
        end
      end
      fwprc_pkg::ST_RD_WAIT: begin
        // Access time plus synchroniser delay, then sample
        if (t_zero) begin
          next_rdata = dq_s2;
          next_pins.ce_n = 1'h1;
          next_pins.oe_n = 1'h1;
          next_pins.a9_hv = 1'h0;
          next_done = 1'h1;
          next_state = fwprc_pkg::ST_IDLE;
        end
      end
      fwprc_pkg::ST_WR_SET: begin
        if (t_zero) begin
          next_pins.we_n = 1'h0;
          t_load = 1'h1;
          t_val = WLOW_CYC;
          next_state = fwprc_pkg::ST_WR_LOW;
        end
      end
      fwprc_pkg::ST_WR_LOW: begin
        // Strobe rises first so data is taken on its edge
        if (t_zero) begin
          next_pins.we_n = 1'h1;
          t_load = 1'h1;
          t_val = HOLD_CYC;
          next_state = fwprc_pkg::ST_WR_HOLD;
        end
      end
      fwprc_pkg::ST_WR_HOLD: begin
        if (t_zero) begin
          next_pins.ce_n = 1'h1;
          next_pins.dq_oe = 1'h0;
          next_done = 1'h1;
          next_state = fwprc_pkg::ST_IDLE;
        end
      end
      fwprc_pkg::ST_PR_SET: begin
        if (t_zero) begin
          next_pins.we_n = 1'h0;
          t_load = 1'h1;
          t_val = PPULSE_CYC;
          next_state = fwprc_pkg::ST_PR_PULSE;
        end
      end
      fwprc_pkg::ST_PR_PULSE: begin
        // address untouched until the strobe rises
        if (t_zero) begin
          next_pins.we_n = 1'h1;
          t_load = 1'h1;
          t_val = HOLD_CYC;
          next_state = fwprc_pkg::ST_PR_HOLD;
        end
      end
      fwprc_pkg::ST_PR_HOLD: begin
        if (t_zero) begin
          next_pins.ce_n = 1'h1;
          next_pins.oe_n = 1'h1;
          next_pins.a9_hv = 1'h0;
          next_done = 1'h1;
          next_state = fwprc_pkg::ST_IDLE;
        end
      end
      fwprc_pkg::ST_RST_LOW: begin
        if (t_zero) begin
          next_pins.rst_n = 1'h1;
          t_load = 1'h1;
          t_val = RH_CYC;
          next_state = fwprc_pkg::ST_RST_WAIT;
        end
      end
      fwprc_pkg::ST_RST_WAIT: begin
        // no read until recovery has run out
        if (t_zero) begin
          next_done = 1'h1;
          next_state = fwprc_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = fwprc_pkg::ST_IDLE;
      end
    endcase
    next_busy = (next_state != fwprc_pkg::ST_IDLE);
  end

  // ------------------------------------------------------------
  // Sequencer registers
  // ------------------------------------------------------------
  // Pins idle: deselected, reset released, protect pin high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= fwprc_pkg::ST_IDLE;
      pins <= '{addr: '0, ce_n: 1'h1, we_n: 1'h1, oe_n: 1'h1, rst_n: 1'h1,
                dq_out: '0, dq_oe: 1'h0, a9_hv: 1'h0, rst_hv: 1'h0,
                protect_accel_pin: 1'h1, accel_hv: 1'h0};
      busy <= 1'h0;
      done <= 1'h0;
      err <= 1'h0;
      rdata <= '0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      busy <= next_busy;
      done <= next_done;
      err <= next_err;
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Helper: length of the protect strobe
  logic [TW-1:0] plow;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      plow <= '0;
    end else if (pins.a9_hv && !pins.we_n) begin
      plow <= plow + TW'(1);
    end else begin
      plow <= '0;
    end
  end

  AST_WRITE_GATE_HIGH: assert property (@(posedge clk) disable iff (!rstn)
    (!pins.we_n && !pins.a9_hv) |-> (pins.oe_n && !pins.ce_n && pins.dq_oe))
    else $error("command write without gate high");
  AST_PROT_PINS: assert property (@(posedge clk) disable iff (!rstn)
    (!pins.we_n && pins.a9_hv) |-> (!pins.oe_n && !pins.ce_n && pins.addr[6:0] == 7'h02))
    else $error("protect pin setup wrong");
  AST_PROT_ADDR_STABLE: assert property (@(posedge clk) disable iff (!rstn)
    (!pins.we_n && pins.a9_hv && !$past(pins.we_n)) |-> $stable(pins.addr))
    else $error("group address moved during protect pulse");
  AST_PROT_WIDTH: assert property (@(posedge clk) disable iff (!rstn)
    ($rose(pins.we_n) && pins.a9_hv) |-> (plow == PPULSE_CYC + TW'(1)))
    else $error("protect pulse length wrong");
  AST_VERIFY_ADDR: assert property (@(posedge clk) disable iff (!rstn)
    (pins.a9_hv && !pins.oe_n && pins.we_n && state == fwprc_pkg::ST_RD_WAIT)
      |-> (pins.addr[1] && pins.addr[6:0] == 7'h02))
    else $error("verify read touches identifier space");
  AST_RESET_WIDTH: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pins.rst_n) |-> (!pins.rst_n) [*8] ##1 (!pins.rst_n) [*2])
    else $error("reset pulse too short");
  AST_NO_READ_AFTER_RESET: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pins.rst_n) |-> (pins.oe_n && busy) [*4])
    else $error("read before recovery delay");
  AST_ACCEL_OFF_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    $fell(pins.accel_hv) |-> $past(rb_s2))
    else $error("accelerate voltage removed while busy");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    done |-> !busy ##1 (!done || $past(req_valid)))
    else $error("done longer than one cycle");

endmodule

`default_nettype wire

// ---- sim/fwprc_flash_model.sv ----
// Purpose: behavioural flash device seen through the controller pins
// Assumes: word mode, one write programs one word, no command decoding
// Notes: viol counts slips of the host side; the bench expects zero
`timescale 1ns/1ps
`default_nettype none
`include "fwprc_cfg.svh"

module fwprc_flash_model #(
  parameter int PROG_NS = 2000,
  parameter int RP_NS = 500,
  parameter int RH_NS = 200,
  parameter logic [8:0] BOOT_GRP = 9'h1FF,
  parameter logic [15:0] ID_CODE = 16'h5A3C // Arbitrary value standing for identifiers
) (
  // Pins from the controller
  input wire fwprc_pkg::fwprc_pins_t pins,
  // Pins back to the controller
  output logic [`FWPRC_DW-1:0] dq_in,
  output logic ry_by,
  // Host slips seen
  output logic [7:0] viol
);
  logic [15:0] mem [int];
  logic [511:0] prot = '0; // shipped unprotected
  logic [20:0] wa;
  logic [15:0] cur;
  logic [15:0] last = 16'h0000;
  logic [15:0] pend;
  logic wr_open = 1'b0;
  logic pr_open = 1'b0;
  logic rdy = 1'b1;
  int tgt;
  int pgm_ns = PROG_NS;
  int mem_ev = 0;
  int nviol = 0;
  realtime t_lo = -1.0e6;
  realtime t_hi = -1.0e6;
  wire drv;

  // Drive only when selected, gated and out of reset
  assign drv = !pins.ce_n && !pins.oe_n && pins.we_n && pins.rst_n;
  // Released bus shows the inverse of the last value, never a kept copy
  assign dq_in = drv ? cur : ~last;
  assign ry_by = rdy;
  assign viol = nviol[7:0];

  // Protect state at low address 02h, else identifier
  always @(pins or mem_ev or prot) begin
    if (pins.a9_hv)
      cur = ({pins.addr[6], pins.addr[3:0]} == 5'h02) ?
            {15'h0000, prot[pins.addr[20:12]]} : ID_CODE;
    else
      cur = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
  end
  always @(cur or drv) if (drv) last <= cur;

  // Address on the later falling strobe
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n && pins.rst_n) begin
      wa = pins.addr;
      if (pins.a9_hv && !pins.oe_n) pr_open = 1'b1;
      else if (pins.oe_n) wr_open = 1'b1;
      else nviol++;
    end
  end

  // Data or protect pulse ends on the first rising strobe
  always @(posedge pins.we_n or posedge pins.ce_n) begin
    if (pr_open && pins.addr[20:12] == wa[20:12] && {wa[6], wa[3:0]} == 5'h02)
      prot[wa[20:12]] = 1'b1;
    else if (pr_open)
      nviol++;
    else if (wr_open && rdy)
      start_pgm(wa, pins.dq_out);
    wr_open = 1'b0;
    pr_open = 1'b0;
  end

  task automatic start_pgm(input logic [20:0] a, input logic [15:0] d);
    logic [8:0] g;
    g = a[20:12];
    if (prot[g] && !pins.rst_hv && !pins.accel_hv) return;
    // Boot group follows the protect pin
    if (g == BOOT_GRP && !pins.protect_accel_pin && !pins.accel_hv) return;
    // Acceleration shortens program time by itself
    pgm_ns = pins.accel_hv ? PROG_NS * 85 / 100 : PROG_NS;
    tgt = a;
    pend = d;
    rdy = 1'b0;
  endtask

  // Program body, cut short by reset
  always @(negedge rdy) begin : pgm_run
    #(pgm_ns);
    mem[tgt] = pend;
    mem_ev++;
    rdy = 1'b1;
  end

  // Reset aborts and spoils the target word
  always @(negedge pins.rst_n) begin
    t_lo = $realtime;
    if (!rdy) begin
      disable pgm_run;
      mem[tgt] = ~pend;
      mem_ev++;
      rdy = 1'b1;
    end
  end
  always @(posedge pins.rst_n) begin
    if ($realtime - t_lo < RP_NS) nviol++;
    t_hi = $realtime;
  end
  always @(posedge drv) if ($realtime - t_hi < RH_NS) nviol++;
  always @(negedge pins.accel_hv) if (!rdy) nviol++;
endmodule
`default_nettype wire

// ---- sim/test_fwprc_ctrl.sv ----
// Purpose: self-checking bench of the flash pin controller with a device model
// Assumes: protect pulse shortened to 9 cycles (timer count 8)
// Notes: expected words come from the bench's own tables
`timescale 1ns/1ps
`default_nettype none
`include "fwprc_cfg.svh"

module test_fwprc_ctrl;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic req_valid = 1'b0;
  fwprc_pkg::fwprc_req_t req = '0;
  logic busy;
  logic done;
  logic err;
  logic [`FWPRC_DW-1:0] rdata;
  logic [`FWPRC_DW-1:0] dq_in;
  logic ry_by;
  fwprc_pkg::fwprc_pins_t pins;
  logic [7:0] viol;
  logic [15:0] got;
  logic gerr;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  fwprc_ctrl #(.PPULSE_CYC(`FWPRC_TW'(8))) i_fwprc_ctrl (.clk(clk), .rstn(rstn),
    .req_valid(req_valid), .req(req), .busy(busy), .done(done), .err(err), .rdata(rdata),
    .pins(pins), .dq_in(dq_in), .ry_by(ry_by));
  fwprc_flash_model i_fwprc_flash_model (.pins(pins), .dq_in(dq_in), .ry_by(ry_by),
    .viol(viol));

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic seen);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask
  // Only pin-sequenced operations keep the controller busy
  function automatic logic exp_busy(input fwprc_pkg::fwprc_op_t op);
    return (op <= fwprc_pkg::OP_RESET);
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // One request held for a single clock, then a bounded wait for done
  task automatic run_op(input fwprc_pkg::fwprc_op_t op, input logic [20:0] a,
                        input logic [15:0] d);
    int k;
    @(posedge clk);
    #5;
    req = '{op, a, d};
    req_valid = 1'b1;
    @(posedge clk);
    #5;
    req_valid = 1'b0;
    chk_bit("busy after take", exp_busy(op), busy);
    k = 0;
    while (done !== 1'b1 && k < 400) begin
      @(posedge clk);
      #5;
      k++;
    end
    if (k == 400) n_errors++;
    chk_bit("busy at done", 1'b0, busy);
    got = rdata;
    gerr = err;
  endtask
  // Device busy line may stay low for the program time
  task automatic wait_rdy();
    int k;
    k = 0;
    while (ry_by !== 1'b1 && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask
  task automatic wr(input logic [20:0] a, input logic [15:0] d);
    run_op(fwprc_pkg::OP_WRITE, a, d);
    wait_rdy();
  endtask
  task automatic rd(input logic [20:0] a);
    run_op(fwprc_pkg::OP_READ, a, 16'h0000);
  endtask

  // Hang guard, counted as a mismatch
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      final_report();
    end
  end

  initial begin
    logic [20:0] ta [8];
    logic [15:0] td [8];
    int i;
    void'($urandom(32'h7DDA));
    repeat (5) @(posedge clk);
    #5;
    rstn = 1'b1;
    chk_word("idle pins", 16'h00F1, {8'h00, pins.ce_n, pins.we_n, pins.oe_n, pins.rst_n,
             pins.dq_oe, pins.a9_hv, pins.rst_hv, pins.protect_accel_pin});
    // Random words in unprotected groups, read back to back
    for (i = 0; i < 8; i++) begin
      ta[i] = {9'(i + 1), 12'($urandom)};
      td[i] = 16'($urandom);
      wr(ta[i], td[i]);
    end
    for (i = 0; i < 8; i++) begin
      rd(ta[i]);
      chk_word("read back", td[i], got);
    end
    $display("test words done");
    // Protect one group, verify it and a neighbour
    run_op(fwprc_pkg::OP_VERIFY, {9'h30, 12'h000}, 16'h0000);
    chk_word("verify fresh", 16'h0000, got);
    run_op(fwprc_pkg::OP_PROTECT, {9'h30, 12'h000}, 16'h0000);
    run_op(fwprc_pkg::OP_VERIFY, {9'h30, 12'h000}, 16'h0000);
    chk_word("verify protected", 16'h0001, got);
    run_op(fwprc_pkg::OP_VERIFY, {9'h31, 12'h000}, 16'h0000);
    chk_word("verify neighbour", 16'h0000, got);
    wr({9'h30, 12'h123}, 16'h1234);
    rd({9'h30, 12'h123});
    chk_word("protected write", 16'hFFFF, got);
    $display("test protect done");
    // Temporary unprotection lifted and restored
    run_op(fwprc_pkg::OP_UNPROT_ON, 21'h000000, 16'h0000);
    chk_bit("reset high voltage", 1'b1, pins.rst_hv);
    wr({9'h30, 12'h124}, 16'h5678);
    run_op(fwprc_pkg::OP_UNPROT_OFF, 21'h000000, 16'h0000);
    wr({9'h30, 12'h125}, 16'h9ABC);
    rd({9'h30, 12'h124});
    chk_word("unprotected write", 16'h5678, got);
    rd({9'h30, 12'h125});
    chk_word("reprotected write", 16'hFFFF, got);
    $display("test unprotect done");
    // Boot group behind the protect pin
    run_op(fwprc_pkg::OP_WP_LOW, 21'h000000, 16'h0000);
    chk_bit("protect pin low", 1'b0, pins.protect_accel_pin);
    wr({9'h1FF, 12'hFF0}, 16'h0F0F);
    rd({9'h1FF, 12'hFF0});
    chk_word("boot blocked", 16'hFFFF, got);
    run_op(fwprc_pkg::OP_WP_HIGH, 21'h000000, 16'h0000);
    wr({9'h1FF, 12'hFF1}, 16'hF0F0);
    rd({9'h1FF, 12'hFF1});
    chk_word("boot open", 16'hF0F0, got);
    $display("test boot done");
    // Acceleration, and its removal refused while programming
    run_op(fwprc_pkg::OP_ACCEL_ON, 21'h000000, 16'h0000);
    chk_bit("accel voltage on", 1'b1, pins.accel_hv);
    wr({9'h30, 12'h200}, 16'h2468);
    rd({9'h30, 12'h200});
    chk_word("accel write", 16'h2468, got);
    run_op(fwprc_pkg::OP_WRITE, {9'h30, 12'h201}, 16'h1357);
    run_op(fwprc_pkg::OP_ACCEL_OFF, 21'h000000, 16'h0000);
    chk_bit("removal refused", 1'b1, gerr);
    chk_bit("accel voltage kept", 1'b1, pins.accel_hv);
    wait_rdy();
    run_op(fwprc_pkg::OP_ACCEL_OFF, 21'h000000, 16'h0000);
    chk_bit("removal taken", 1'b0, gerr);
    chk_bit("accel voltage off", 1'b0, pins.accel_hv);
    $display("test accel done");
    // Reset in mid-program, then a read after wake-up
    run_op(fwprc_pkg::OP_WRITE, {9'h0A, 12'h300}, 16'hAAAA);
    run_op(fwprc_pkg::OP_RESET, 21'h000000, 16'h0000);
    chk_bit("ready after reset", 1'b1, ry_by);
    rd(ta[0]);
    chk_word("read after reset", td[0], got);
    $display("test reset done");
    // Unknown codes answered with an error, cleared by the next request
    for (i = 11; i < 16; i++) begin
      run_op(fwprc_pkg::fwprc_op_t'(i[3:0]), 21'($urandom), 16'($urandom));
      chk_bit("unknown op", 1'b1, gerr);
    end
    rd(ta[1]);
    chk_bit("error cleared", 1'b0, gerr);
    chk_word("read after error", td[1], got);
    chk_word("host slips", 16'h0000, {8'h00, viol});
    $display("test misc done");
    final_report();
  end
endmodule
`default_nettype wire
